/* File: bench/tb_top.sv */
/*
  Self-checking bench for the segment-load and flag-control decoder.
  Assumes sld_pkg and sld_decode are compiled first; the bench drives every port itself.
*/
`timescale 1ns/10ps

module tb_top;
  import sld_pkg::*;

  // One instruction: bytes packed from the top, expected timing, operation and flags.
  typedef struct {
    logic [23:0] bytes;
    int n;
    int cyc;
    sld_op_t op;
    logic bad;
    logic [2:0] dreg;
    sld_flags_t fl;
  } sld_row_t;

  logic i_sys_clk;
  logic i_reset;
  logic i_byte_valid;
  logic [7:0] i_byte;
  logic o_byte_ready;
  sld_cmd_t o_cmd;
  logic o_busy;
  logic o_done;
  logic o_invalid;
  sld_flags_t o_flags;
  int err_count;
  int checks;
  int cyc;
  sld_row_t rows [14];

  sld_decode dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .o_byte_ready(o_byte_ready), .o_cmd(o_cmd), .o_busy(o_busy),
    .o_done(o_done), .o_invalid(o_invalid), .o_flags(o_flags));

  // Free-running 50 ns clock.
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Counts one comparison and reports it when it does not hold.
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // Offers bytes in order, each held until an edge where ready is high.
  // Ready is read once it has settled, so it is the value that the next edge samples.
  task send(input logic [23:0] bytes, input int n);
    int w;
    logic rdy;
    @(posedge i_sys_clk);
    i_byte_valid <= 1'b1;
    i_byte <= bytes[23:16];
    for (int i = 0; i < n; i++)
    begin
      w = 0;
      do
      begin
        #1;
        rdy = o_byte_ready;
        @(posedge i_sys_clk);
        w++;
      end while (rdy !== 1'b1 && w < 20);
      if (w >= 20)
      begin
        chk(1'b0, "byte never taken");
        final_report();
      end
      bytes = bytes << 8;
      i_byte <= bytes[23:16];
      i_byte_valid <= (i < n - 1);
    end
  endtask : send

  // Counts cycles from the last byte taken, that cycle included, to the completion pulse.
  task wait_end(output int c);
    c = 1;
    do
    begin
      @(posedge i_sys_clk);
      #1;
      c++;
      if (o_done !== 1'b1 && o_invalid !== 1'b1)
        chk(o_busy === 1'b1 && o_byte_ready === 1'b0, "idle during execution");
    end while (o_done !== 1'b1 && o_invalid !== 1'b1 && c < 40);
    if (c >= 40)
    begin
      chk(1'b0, "no completion");
      final_report();
    end
  endtask : wait_end

  // Main sequence: reset, table of instructions, then mid-run reset.
  initial
  begin
    err_count = 0;
    checks = 0;
    i_reset = 1'b1;
    i_byte_valid = 1'b0;
    i_byte = 8'h00;
    rows = '{
      '{24'hf50000, 1, 2, SLD_OP_INVERT_CARRY, 1'b0, 3'h0, 4'h8},
      '{24'hf50000, 1, 2, SLD_OP_INVERT_CARRY, 1'b0, 3'h0, 4'h0},
      '{24'hf50000, 1, 2, SLD_OP_INVERT_CARRY, 1'b0, 3'h0, 4'h8},
      '{24'hfa0000, 1, 8, SLD_OP_CLEAR_INT, 1'b0, 3'h0, 4'h8},
      '{24'h0f0600, 2, 5, SLD_OP_CLEAR_TS, 1'b0, 3'h0, 4'h8},
      '{24'hfc0000, 1, 2, SLD_OP_CLEAR_DIR, 1'b0, 3'h0, 4'h8},
      '{24'h0fb42c, 3, 29, SLD_OP_LOAD_AUX_A, 1'b0, 3'h5, 4'h8},
      '{24'h0fb55e, 3, 29, SLD_OP_LOAD_AUX_B, 1'b0, 3'h3, 4'h8},
      '{24'h0fb284, 3, 26, SLD_OP_LOAD_STACK, 1'b0, 3'h0, 4'h8},
      '{24'h0fb4c8, 3, 2, SLD_OP_INVALID, 1'b1, 3'h0, 4'h8},
      '{24'h0fb5ff, 3, 2, SLD_OP_INVALID, 1'b1, 3'h0, 4'h8},
      '{24'h900000, 1, 2, SLD_OP_INVALID, 1'b1, 3'h0, 4'h8},
      '{24'h0f0100, 2, 2, SLD_OP_INVALID, 1'b1, 3'h0, 4'h8},
      '{24'hf80000, 1, 2, SLD_OP_CLEAR_CARRY, 1'b0, 3'h0, 4'h0}};
    repeat (12) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    chk(o_byte_ready === 1'b1 && o_busy === 1'b0 && o_done === 1'b0, "reset outputs");
    chk(o_flags === 4'h0 && o_cmd === '0 && o_invalid === 1'b0, "reset flags");
    foreach (rows[k])
    begin
      send(rows[k].bytes, rows[k].n);
      wait_end(cyc);
      chk(cyc == rows[k].cyc, "completion time");
      chk(o_invalid === rows[k].bad && o_done === !rows[k].bad, "pulse kind");
      chk(o_cmd.op === rows[k].op, "operation");
      if (rows[k].n == 3 && !rows[k].bad)
        chk(o_cmd.dest_reg === rows[k].dreg && o_cmd.modrm === rows[k].bytes[7:0], "modrm");
      chk(o_flags === rows[k].fl, "flags");
      @(posedge i_sys_clk);
      #1;
      chk(o_done === 1'b0 && o_invalid === 1'b0, "pulse too long");
    end
    // Reset in the middle of a long load, with carry set beforehand.
    send(24'hf50000, 1);
    wait_end(cyc);
    @(posedge i_sys_clk);
    send(24'h0fb42c, 3);
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    chk(o_busy === 1'b0 && o_byte_ready === 1'b1 && o_flags === 4'h0, "mid-run reset");
    repeat (30)
    begin
      @(posedge i_sys_clk);
      #1;
      chk(o_done === 1'b0, "stale completion");
    end
    send(24'hf80000, 1);
    wait_end(cyc);
    chk(cyc == 2 && o_done === 1'b1, "after reset");
    final_report();
  end

endmodule : tb_top

/* File: hdl/sld_decode.sv */
/*
  Decoder and execution timer for far-pointer segment loads and flag control.
  Takes one instruction byte per cycle from the prefetch queue with valid/ready.
  Assumes the execution unit performs the memory part of a segment load itself.
*/
`timescale 1ns/10ps

module sld_decode
  import sld_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Byte stream from the prefetch queue.
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  // Decoded operation and completion.
  output sld_cmd_t o_cmd,
  output logic o_busy,
  output logic o_done,
  output logic o_invalid,
  // Architectural flags.
  output sld_flags_t o_flags
);

  typedef enum logic [4:0] {
    ST_FIRST = 5'h01,
    ST_SECOND = 5'h02,
    ST_MODRM = 5'h04,
    ST_EXEC = 5'h08,
    ST_DONE = 5'h10
  } sld_state_t;

  sld_state_t state;
  sld_op_t pend_op;
  logic [4:0] count;
  logic take;
  logic is_reg_form;

  assign take = i_byte_valid && o_byte_ready;
  assign is_reg_form = i_byte[MODRM_MOD_HI:MODRM_MOD_LO] == MODRM_MOD_REG;

  // Clock count of an operation, counting the cycle the last byte is taken.
  function automatic logic [4:0] op_clocks(input sld_op_t op);
    case (op)
      SLD_OP_LOAD_AUX_A: op_clocks = CLK_LOAD_AUX;
      SLD_OP_LOAD_AUX_B: op_clocks = CLK_LOAD_AUX;
      SLD_OP_LOAD_STACK: op_clocks = CLK_LOAD_STACK;
      SLD_OP_CLEAR_TS: op_clocks = CLK_CLEAR_TS;
      SLD_OP_CLEAR_INT: op_clocks = CLK_CLEAR_INT;
      default: op_clocks = CLK_FLAG_SHORT;
    endcase
  endfunction : op_clocks

  // Sequencer: gathers bytes, then counts out the operation's clocks.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      state <= ST_FIRST;
      pend_op <= SLD_OP_NONE;
      count <= 5'h00;
      o_byte_ready <= 1'b1;
      o_cmd <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_invalid <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      o_invalid <= 1'b0;
      case (state)
        ST_FIRST:
          if (take)
          begin
            o_busy <= 1'b1;
            case (i_byte)
              OPC_ESCAPE: state <= ST_SECOND;
              OPC_CLEAR_CARRY: pend_op <= SLD_OP_CLEAR_CARRY;
              OPC_CLEAR_DIR: pend_op <= SLD_OP_CLEAR_DIR;
              OPC_INVERT_CARRY: pend_op <= SLD_OP_INVERT_CARRY;
              OPC_CLEAR_INT: pend_op <= SLD_OP_CLEAR_INT;
              default: pend_op <= SLD_OP_INVALID;
            endcase
            if (i_byte != OPC_ESCAPE)
            begin
              state <= ST_EXEC;
              o_byte_ready <= 1'b0;
              count <= CLK_FLAG_SHORT - 5'h01;
              if (i_byte == OPC_CLEAR_INT)
                count <= CLK_CLEAR_INT - 5'h01;
            end
          end
        ST_SECOND:
          if (take)
          begin
            case (i_byte)
              OPC_LOAD_AUX_A: pend_op <= SLD_OP_LOAD_AUX_A;
              OPC_LOAD_AUX_B: pend_op <= SLD_OP_LOAD_AUX_B;
              OPC_LOAD_STACK: pend_op <= SLD_OP_LOAD_STACK;
              OPC_CLEAR_TS: pend_op <= SLD_OP_CLEAR_TS;
              default: pend_op <= SLD_OP_INVALID;
            endcase
            if (i_byte == OPC_LOAD_AUX_A || i_byte == OPC_LOAD_AUX_B
                || i_byte == OPC_LOAD_STACK)
              state <= ST_MODRM;
            else
            begin
              state <= ST_EXEC;
              o_byte_ready <= 1'b0;
              count <= (i_byte == OPC_CLEAR_TS) ? CLK_CLEAR_TS - 5'h01 : 5'h01;
            end
          end
        ST_MODRM:
          if (take)
          begin
            o_byte_ready <= 1'b0;
            o_cmd.modrm <= i_byte;
            o_cmd.dest_reg <= i_byte[MODRM_REG_HI:MODRM_REG_LO];
            if (is_reg_form)
            begin
              pend_op <= SLD_OP_INVALID;
              count <= CLK_FLAG_SHORT - 5'h01;
            end
            else
              count <= op_clocks(pend_op) - 5'h01;
            state <= ST_EXEC;
          end
        ST_EXEC:
        begin
          o_cmd.op <= pend_op;
          if (count == 5'h01)
          begin
            state <= ST_DONE;
            o_done <= (pend_op != SLD_OP_INVALID);
            o_invalid <= (pend_op == SLD_OP_INVALID);
            o_busy <= 1'b0;
            o_byte_ready <= 1'b1;
          end
          count <= count - 5'h01;
        end
        ST_DONE:
        begin
          state <= ST_FIRST;
          pend_op <= SLD_OP_NONE;
          if (take)
          begin
            state <= ST_FIRST;
          end
        end
        default: state <= ST_FIRST;
      endcase
      if (state == ST_DONE && take)
        state <= ST_FIRST;
    end
  end

  // Flag updates land on the completion cycle of each flag operation.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_flags <= '{RST_CARRY, RST_DIR, RST_INT_EN, RST_TASK_SW};
    end
    else if (state == ST_EXEC && count == 5'h01)
    begin
      case (pend_op)
        SLD_OP_CLEAR_CARRY: o_flags.carry <= 1'b0;
        SLD_OP_INVERT_CARRY: o_flags.carry <= ~o_flags.carry;
        SLD_OP_CLEAR_DIR: o_flags.direction <= 1'b0;
        SLD_OP_CLEAR_INT: o_flags.int_enable <= 1'b0;
        SLD_OP_CLEAR_TS: o_flags.task_switched <= 1'b0;
        default: o_flags <= o_flags;
      endcase
    end
  end

  // Cycles from the last byte taken to the completion pulse.
  logic [5:0] since_last;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      since_last <= 6'h00;
    else if (take && state != ST_FIRST && state != ST_SECOND)
      since_last <= 6'h01;
    else if (take && state == ST_FIRST && i_byte != OPC_ESCAPE)
      since_last <= 6'h01;
    else if (take && state == ST_SECOND && i_byte != OPC_LOAD_AUX_A
             && i_byte != OPC_LOAD_AUX_B && i_byte != OPC_LOAD_STACK)
      since_last <= 6'h01;
    else if (since_last != 6'h00 && since_last != 6'h3f)
      since_last <= since_last + 6'h01;
  end

  chk_aux_load_time: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_LOAD_AUX_A) |-> since_last == {1'b0, CLK_LOAD_AUX})
    else $error("aux segment a load not done in 29 clocks");
  chk_auxb_load_time: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_LOAD_AUX_B) |-> since_last == {1'b0, CLK_LOAD_AUX})
    else $error("aux segment b load not done in 29 clocks");
  chk_stack_load_time: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_LOAD_STACK) |-> since_last == {1'b0, CLK_LOAD_STACK})
    else $error("stack segment load not done in 26 clocks");
  chk_clear_carry: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_CLEAR_CARRY)
    |-> !o_flags.carry && since_last == {1'b0, CLK_FLAG_SHORT})
    else $error("carry clear wrong");
  chk_clear_dir: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_CLEAR_DIR)
    |-> !o_flags.direction && since_last == {1'b0, CLK_FLAG_SHORT})
    else $error("direction clear wrong");
  chk_clear_ts: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_CLEAR_TS)
    |-> !o_flags.task_switched && since_last == {1'b0, CLK_CLEAR_TS})
    else $error("task switched clear wrong");
  chk_invert_carry: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_INVERT_CARRY)
    |-> o_flags.carry != $past(o_flags.carry) && since_last == {1'b0, CLK_FLAG_SHORT})
    else $error("carry not inverted");
  chk_clear_int: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_done && (o_cmd.op == SLD_OP_CLEAR_INT)
    |-> !o_flags.int_enable && since_last == {1'b0, CLK_CLEAR_INT})
    else $error("interrupt enable clear wrong");
  chk_reg_form_bad: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    state == ST_MODRM && take && is_reg_form
    |-> ##2 o_invalid && !o_done && o_cmd.op == SLD_OP_INVALID)
    else $error("register form segment load not refused");

endmodule : sld_decode

/* File: hdl/sld_pkg.sv */
/*
  Package for the segment-load and flag-control decode slice.
  Holds opcode encodings, clock counts and the carrier structs shared by the design.
  Assumes a single core clock and a byte-wide feed from the prefetch queue.
*/
package sld_pkg;

  // Opcode bytes.
  localparam logic [7:0] OPC_ESCAPE = 8'h0f;
  localparam logic [7:0] OPC_LOAD_AUX_A = 8'hb4;
  localparam logic [7:0] OPC_LOAD_AUX_B = 8'hb5;
  localparam logic [7:0] OPC_LOAD_STACK = 8'hb2;
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'hf8;
  localparam logic [7:0] OPC_CLEAR_DIR = 8'hfc;
  localparam logic [7:0] OPC_CLEAR_TS = 8'h06;
  localparam logic [7:0] OPC_INVERT_CARRY = 8'hf5;
  localparam logic [7:0] OPC_CLEAR_INT = 8'hfa;

  // Modrm field layout.
  localparam int MODRM_MOD_HI = 7;
  localparam int MODRM_MOD_LO = 6;
  localparam int MODRM_REG_HI = 5;
  localparam int MODRM_REG_LO = 3;
  localparam logic [1:0] MODRM_MOD_REG = 2'h3;

  // Clock counts of each operation.
  localparam logic [4:0] CLK_LOAD_AUX = 5'h1d;
  localparam logic [4:0] CLK_LOAD_STACK = 5'h1a;
  localparam logic [4:0] CLK_FLAG_SHORT = 5'h02;
  localparam logic [4:0] CLK_CLEAR_TS = 5'h05;
  localparam logic [4:0] CLK_CLEAR_INT = 5'h08;

  // Reset values of the flags handled here.
  localparam logic RST_CARRY = 1'b0;
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_INT_EN = 1'b0;
  localparam logic RST_TASK_SW = 1'b0;

  // Decoded operations.
  typedef enum logic [3:0] {
    SLD_OP_NONE = 4'h0,
    SLD_OP_LOAD_AUX_A = 4'h1,
    SLD_OP_LOAD_AUX_B = 4'h2,
    SLD_OP_LOAD_STACK = 4'h3,
    SLD_OP_CLEAR_CARRY = 4'h4,
    SLD_OP_CLEAR_DIR = 4'h5,
    SLD_OP_CLEAR_TS = 4'h6,
    SLD_OP_INVERT_CARRY = 4'h7,
    SLD_OP_CLEAR_INT = 4'h8,
    SLD_OP_INVALID = 4'h9
  } sld_op_t;

  // Flags touched by this slice.
  typedef struct packed {
    logic carry;
    logic direction;
    logic int_enable;
    logic task_switched;
  } sld_flags_t;

  // Decoded operation handed to the execution unit.
  typedef struct packed {
    sld_op_t op;
    logic [2:0] dest_reg;
    logic [7:0] modrm;
  } sld_cmd_t;

endpackage : sld_pkg
